// ==== sbarc_pkg.sv ====
// shared constants and types of the secondary arbiter and clock control block
`default_nettype none

package sbarc_pkg;

  // request/grant pairs and secondary clock outputs
  localparam int NUM_REQ = 4;
  localparam int NUM_CLK = 5;

  // least number of cycles a grant stays off before it may return
  localparam int         GNT_HOLDOFF = 2;
  // counter load that yields exactly the holdoff above
  localparam logic [1:0] HOLD_LOAD   = 2'(GNT_HOLDOFF - 1);

  // reset values of the pin registers
  localparam logic RST_PERR_N = 1'b1;
  localparam logic RST_SEC_N  = 1'b0;

  // device power states
  typedef enum logic [1:0]
  {
    PWR_D0    = 2'h0,
    PWR_D1    = 2'h1,
    PWR_D2    = 2'h2,
    PWR_D3HOT = 2'h3
  } sbarc_pwr_t;

  // parity error pin sequencer
  typedef enum logic [1:0]
  {
    PERR_IDLE = 2'h0,
    PERR_LOW  = 2'h1,
    PERR_HIGH = 2'h2
  } sbarc_perr_t;

endpackage

`default_nettype wire

// ==== sbarc_arb_if.sv ====
// request and grant carrier between the top level and the arbiter
`timescale 1ns/100ps
`default_nettype none

interface sbarc_arb_if
#(
  parameter int N = 4
);
  logic [N-1:0] req;
  logic [N-1:0] gnt;
  logic         enable;
  logic         bus_busy;

  modport ctl (output req, output enable, output bus_busy, input gnt);
  modport arb (input req, input enable, input bus_busy, output gnt);
endinterface

`default_nettype wire

// ==== sbarc_arbiter.sv ====
// rotating priority arbiter for the external secondary masters
`timescale 1ns/100ps
`default_nettype none

module sbarc_arbiter
#(
  parameter int N = 4
)
(
  // secondary clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // requests and grants, active high
  sbarc_arb_if.arb    a
);
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  logic [N-1:0]  gnt_r;
  logic [N-1:0]  gnt_nxt;
  logic [IW-1:0] last_r;
  logic [IW-1:0] pick_idx;
  logic [IW-1:0] cand;
  logic          pick_vld;
  logic [1:0]    cool_r [N];
  logic [N-1:0]  gnt_d_r;
  logic          started_r;

  assign a.gnt = gnt_r;

  // search from the entry after the last winner
  always_comb
  begin
    pick_vld = 1'b0;
    pick_idx = last_r;
    cand     = '0;
    for (int k = 1; k <= N; k++)
    begin
      cand = IW'((int'(last_r) + k) % N);
      if (!pick_vld && a.req[cand] && cool_r[cand] == 2'h0)
      begin
        pick_vld = 1'b1;
        pick_idx = cand;
      end
    end
  end

  // grant kept while requested, moved once the owner started
  always_comb
  begin
    gnt_nxt = gnt_r;
    if (rst_i || !a.enable)
      gnt_nxt = '0;
    else if (|gnt_r)
    begin
      if (!(|(a.req & gnt_r)) || ((|(a.req & ~gnt_r)) && a.bus_busy && started_r))
        gnt_nxt = '0;
    end
    else if (pick_vld)
    begin
      gnt_nxt = '0;
      gnt_nxt[pick_idx] = 1'b1;
    end
  end

  // grant and rotation state
  always_ff @(posedge clk_i)
  begin
    gnt_r <= gnt_nxt;
    if (rst_i)
      last_r <= IW'(N - 1);
    else if (!(|gnt_r) && (|gnt_nxt))
      last_r <= pick_idx;
  end

  // owner counts as started once the bus was idle while its pin was out;
  // a busy bus left over from the previous owner must not steal the grant
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gnt_d_r   <= '0;
      started_r <= 1'b0;
    end
    else
    begin
      gnt_d_r <= gnt_r;
      if (!(|gnt_nxt))
        started_r <= 1'b0;
      else if ((|(gnt_r & gnt_d_r)) && !a.bus_busy)
        started_r <= 1'b1;
    end
  end

  // per line holdoff after a grant is removed
  for (genvar i = 0; i < N; i++)
  begin : g_cool
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cool_r[i] <= 2'h0;
      else if (gnt_r[i] && !gnt_nxt[i])
        cool_r[i] <= sbarc_pkg::HOLD_LOAD;
      else if (cool_r[i] != 2'h0)
        cool_r[i] <= cool_r[i] - 2'h1;
    end

    gnt_holdoff_a: assert property (
      @(posedge clk_i) disable iff (rst_i) $fell(gnt_r[i]) |=> !gnt_r[i])
      else $error("grant returned before holdoff");

    gnt_cause_a: assert property (
      @(posedge clk_i) disable iff (rst_i) $rose(gnt_r[i]) |-> $past(a.req[i] && a.enable))
      else $error("grant without request");
  end

  gnt_onehot_a: assert property (
    @(posedge clk_i) disable iff (rst_i) $onehot0(gnt_r))
    else $error("more than one grant");

endmodule

`default_nettype wire

// ==== sbarc_clkout.sv ====
// gated secondary clock outputs divided from the primary clock
`timescale 1ns/100ps
`default_nettype none

module sbarc_clkout
#(
  parameter int N = 5
)
(
  // primary clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // per output run enable and clock
  input  wire logic [N-1:0] run_i,
  output logic      [N-1:0] clk_o
);
  // all running outputs toggle on the same primary edge
  for (genvar i = 0; i < N; i++)
  begin : g_clk
    // stopping forces low; from high this is the natural fall, so no runt
    always_ff @(posedge clk_i)
    begin
      if (rst_i || !run_i[i])
        clk_o[i] <= 1'b0;
      else
        clk_o[i] <= ~clk_o[i];
    end

    clk_toggle_a: assert property (
      @(posedge clk_i) disable iff (rst_i) run_i[i] |=> clk_o[i] != $past(clk_o[i]))
      else $error("running clock did not toggle");

    clk_stop_a: assert property (
      @(posedge clk_i) disable iff (rst_i) !run_i[i] |=> !clk_o[i])
      else $error("stopped clock not held low");
  end
endmodule

`default_nettype wire

// ==== sbarc_top.sv ====
// secondary side arbiter, reset, error and clock control of the bridge
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Parity error pin goes low when received secondary data has bad parity.
// - Parity error pin is driven high one cycle before it floats.
// - Arbiter grants a master by pulling its matching active-low grant low.
// - A removed grant stays high at least two secondary cycles.
// - Idle bus with no external grant is parked: AD, CBE and PAR driven.
// - Secondary reset asserts on primary reset or the software reset bit.
// - During secondary reset controls float and AD, CBE, PAR drive zero.
// - Central function strap low enables the arbiter; high leaves it unused.
// - External arbiter: request zero is our grant, grant zero our request.
// - Five secondary clock outputs run in phase with the primary clock.
// - Each secondary clock output can be disabled by its software bit.
// - Gating strap high with D2 or D3hot puts the secondary bus in B2.
// - In B2 all secondary clock outputs stop and hold low.
// - Gating strap low: D2 or D3hot leave the secondary clocks running.
// - Scan test mode input low enables the scan chains.
// - In scan test mode a low scan enable selects shift.
// - In scan test mode a high scan enable selects capture.
// - Outside scan test mode the scan enable pin drives logic zero.
module sbarc_top
#(
  parameter int NUM_REQ = sbarc_pkg::NUM_REQ,
  parameter int NUM_CLK = sbarc_pkg::NUM_CLK
)
(
  // primary clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  // secondary link clock
  input  wire logic                  sec_clk_i,
  // software control and power state
  input  wire logic                  sec_reset_ctrl_i,
  input  wire logic [NUM_CLK-1:0]    sec_clk_disable_i,
  input  wire sbarc_pkg::sbarc_pwr_t power_state_i,
  // strap pins
  input  wire logic                  central_function_strap_i,
  input  wire logic                  power_clock_gating_strap_i,
  // scan pins and scan controls
  input  wire logic                  scan_test_mode_n_i,
  input  wire logic                  scan_en_i,
  output logic                       scan_en_o,
  output logic                       scan_en_oe_o,
  output logic                       scan_chain_en_o,
  output logic                       scan_shift_o,
  output logic                       scan_capture_o,
  // secondary reset and clocks
  output logic                       sec_reset_n_o,
  output logic [NUM_CLK-1:0]         sec_clock_outputs_o,
  // system error
  input  wire logic                  sec_system_error_n_i,
  output logic                       sec_system_error_o,
  // arbitration pins, secondary clock
  input  wire logic [NUM_REQ-1:0]    sec_req_n_i,
  output logic      [NUM_REQ-1:0]    sec_gnt_n_o,
  output logic      [NUM_REQ-1:0]    sec_gnt_oe_o,
  // bridge master and bus state, secondary clock
  input  wire logic                  own_bus_req_i,
  input  wire logic                  bus_idle_i,
  output logic                       own_bus_grant_o,
  output logic                       ad_drive_o,
  output logic                       ad_zero_o,
  // parity error pin, secondary clock
  input  wire logic                  parity_err_det_i,
  output logic                       sec_parity_error_n_o,
  output logic                       sec_parity_error_oe_o
);

  // core domain synchronisers and state
  logic                  pcg_s1;
  logic                  pcg_s2;
  logic                  tm_s1;
  logic                  tm_s2;
  logic                  sen_s1;
  logic                  sen_s2;
  logic                  serr_s1;
  logic                  serr_s2;
  logic                  sec_rst_req_r;
  logic                  b2_r;
  logic [NUM_CLK-1:0]    clk_run;

  // secondary domain synchronisers and state
  logic                  srst_s1;
  logic                  srst;
  logic                  cfn_s1;
  logic                  cfn_s2;
  logic [NUM_REQ-1:0]    req_s1;
  logic [NUM_REQ-1:0]    req_s2;
  logic                  internal;
  logic                  parked;
  sbarc_pkg::sbarc_perr_t perr_st_r;
  sbarc_pkg::sbarc_perr_t perr_nxt;

  sbarc_arb_if #(.N(NUM_REQ)) arb ();

  // pin levels into the primary domain, two flops each
  always_ff @(posedge core_clk_i)
  begin
    pcg_s1  <= power_clock_gating_strap_i;
    pcg_s2  <= pcg_s1;
    tm_s1   <= scan_test_mode_n_i;
    tm_s2   <= tm_s1;
    sen_s1  <= scan_en_i;
    sen_s2  <= sen_s1;
    serr_s1 <= sec_system_error_n_i;
    serr_s2 <= serr_s1;
  end

  always_ff @(posedge core_clk_i)
  begin
    sec_rst_req_r <= reset_i || sec_reset_ctrl_i;
    sec_reset_n_o <= !(reset_i || sec_reset_ctrl_i);
  end

  // system error pin is only observed
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      sec_system_error_o <= 1'b0;
    else
      sec_system_error_o <= !serr_s2;
  end

  // bus power state follows device state only with the strap high
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      b2_r <= 1'b0;
    else
      b2_r <= pcg_s2 && (power_state_i == sbarc_pkg::PWR_D2 ||
                         power_state_i == sbarc_pkg::PWR_D3HOT);
  end

  // software disable and bus power state both stop a clock
  assign clk_run = ~sec_clk_disable_i & ~{NUM_CLK{b2_r}};

  sbarc_clkout #(.N(NUM_CLK)) u_clkout
  (
    .clk_i (core_clk_i),
    .rst_i (reset_i),
    .run_i (clk_run),
    .clk_o (sec_clock_outputs_o)
  );

  // scan controls from the synchronised test mode
  always_ff @(posedge core_clk_i)
  begin
    scan_en_o       <= 1'b0;
    scan_chain_en_o <= !tm_s2;
    scan_en_oe_o    <= tm_s2;
    scan_shift_o    <= !tm_s2 && !sen_s2;
    scan_capture_o  <= !tm_s2 && sen_s2;
  end

  // reset, strap and request pins into the secondary domain
  always_ff @(posedge sec_clk_i)
  begin
    srst_s1 <= sec_rst_req_r;
    srst    <= srst_s1;
    cfn_s1  <= central_function_strap_i;
    cfn_s2  <= cfn_s1;
    req_s1  <= sec_req_n_i;
    req_s2  <= req_s1;
  end

  // strap low selects the internal arbiter
  assign internal     = !cfn_s2;
  // requests are active low on the pins
  assign arb.req      = internal ? ~req_s2 : '0;
  assign arb.enable   = internal && !srst;
  assign arb.bus_busy = !bus_idle_i;

  sbarc_arbiter #(.N(NUM_REQ)) u_arb
  (
    .clk_i (sec_clk_i),
    .rst_i (srst),
    .a     (arb)
  );

  // bridge owns an idle bus when no external grant is out
  assign parked = bus_idle_i && (internal ? !(|arb.gnt) : !req_s2[0]);

  // grant pins float in reset; external arbiter reuse
  always_ff @(posedge sec_clk_i)
  begin
    if (srst)
    begin
      sec_gnt_n_o  <= '1;
      sec_gnt_oe_o <= '0;
    end
    else if (internal)
    begin
      sec_gnt_n_o  <= ~arb.gnt;
      sec_gnt_oe_o <= '1;
    end
    else
    begin
      sec_gnt_n_o  <= {{(NUM_REQ-1){1'b1}}, !own_bus_req_i};
      sec_gnt_oe_o <= {{(NUM_REQ-1){1'b0}}, 1'b1};
    end
  end

  // zeros driven on the data lines throughout reset
  always_ff @(posedge sec_clk_i)
  begin
    if (srst)
    begin
      own_bus_grant_o <= 1'b0;
      ad_drive_o      <= 1'b1;
      ad_zero_o       <= 1'b1;
    end
    else
    begin
      own_bus_grant_o <= internal ? !(|arb.gnt) : !req_s2[0];
      ad_drive_o      <= parked;
      ad_zero_o       <= 1'b0;
    end
  end

  // a new error restarts the low phase
  always_comb
  begin
    perr_nxt = sbarc_pkg::PERR_IDLE;
    if (srst)
      perr_nxt = sbarc_pkg::PERR_IDLE;
    else if (parity_err_det_i)
      perr_nxt = sbarc_pkg::PERR_LOW;
    else
    begin
      unique case (perr_st_r)
        sbarc_pkg::PERR_LOW:  perr_nxt = sbarc_pkg::PERR_HIGH;
        sbarc_pkg::PERR_HIGH: perr_nxt = sbarc_pkg::PERR_IDLE;
        sbarc_pkg::PERR_IDLE: perr_nxt = sbarc_pkg::PERR_IDLE;
        default:              perr_nxt = sbarc_pkg::PERR_IDLE;
      endcase
    end
  end

  // high for one cycle before the pin is released
  always_ff @(posedge sec_clk_i)
  begin
    if (srst)
    begin
      perr_st_r             <= sbarc_pkg::PERR_IDLE;
      sec_parity_error_n_o  <= sbarc_pkg::RST_PERR_N;
      sec_parity_error_oe_o <= 1'b0;
    end
    else
    begin
      perr_st_r             <= perr_nxt;
      sec_parity_error_n_o  <= perr_nxt != sbarc_pkg::PERR_LOW;
      sec_parity_error_oe_o <= perr_nxt != sbarc_pkg::PERR_IDLE;
    end
  end

  // parity error pin phases
  sequence perr_low_s;
    !sec_parity_error_n_o && sec_parity_error_oe_o;
  endsequence

  sequence perr_high_s;
    sec_parity_error_n_o && sec_parity_error_oe_o;
  endsequence

  perr_assert_a: assert property (
    @(posedge sec_clk_i) disable iff (srst) parity_err_det_i |=> perr_low_s)
    else $error("parity error not signalled");

  perr_deassert_a: assert property (
    @(posedge sec_clk_i) disable iff (srst)
    perr_low_s ##0 !parity_err_det_i ##1 !parity_err_det_i |-> perr_high_s ##1 !sec_parity_error_oe_o)
    else $error("parity pin not driven high before release");

  perr_float_a: assert property (
    @(posedge sec_clk_i) disable iff (srst) $fell(sec_parity_error_oe_o) |-> $past(perr_high_s))
    else $error("parity pin released without high cycle");

  reset_float_a: assert property (
    @(posedge sec_clk_i) disable iff (1'b0)
    srst |=> sec_gnt_oe_o == '0 && !sec_parity_error_oe_o && ad_zero_o && ad_drive_o)
    else $error("controls not floated during reset");

  park_drive_a: assert property (
    @(posedge sec_clk_i) disable iff (srst)
    internal && bus_idle_i && !(|arb.gnt) |=> ad_drive_o && sec_gnt_n_o == '1)
    else $error("idle bus not parked");

  arb_off_a: assert property (
    @(posedge sec_clk_i) disable iff (srst) !internal |=> arb.gnt == '0)
    else $error("arbiter granted while strapped external");

  ext_arb_a: assert property (
    @(posedge sec_clk_i) disable iff (srst) !internal ##1 !internal |->
    sec_gnt_oe_o[0] && sec_gnt_n_o[0] == !$past(own_bus_req_i) &&
    own_bus_grant_o == !$past(req_s2[0]))
    else $error("external arbiter pin reuse wrong");

  srst_assert_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) sec_reset_ctrl_i |=> !sec_reset_n_o)
    else $error("secondary reset not asserted");

  srst_release_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(sec_reset_n_o) |-> $past(!reset_i && !sec_reset_ctrl_i))
    else $error("secondary reset released early");

  b2_enter_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    pcg_s2 && power_state_i == sbarc_pkg::PWR_D3HOT ##1 b2_r |=> sec_clock_outputs_o == '0)
    else $error("clocks run in bus power state B2");

  b2_ignore_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) !pcg_s2 |=> !b2_r)
    else $error("clocks gated with strap low");

  clk_disable_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    ($past(sec_clk_disable_i) & sec_clock_outputs_o) == '0)
    else $error("disabled clock output running");

  serr_seen_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) !serr_s2 |=> sec_system_error_o)
    else $error("system error not reported");

  scan_chain_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) !tm_s2 |=> scan_chain_en_o)
    else $error("scan chains not enabled");

  scan_shift_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) !tm_s2 && !sen_s2 |=> scan_shift_o)
    else $error("shift not selected");

  scan_capture_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i) !tm_s2 && sen_s2 |=> scan_capture_o)
    else $error("capture not selected");

  scan_normal_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    tm_s2 |=> scan_en_oe_o && !scan_en_o && !scan_shift_o && !scan_capture_o)
    else $error("scan enable not driven low");

endmodule

`default_nettype wire

// ==== sbarc_master_model.sv ====
// behavioural model of the external masters on the secondary bus
`timescale 1ns/100ps
`default_nettype none

module sbarc_master_model
#(
  parameter int N       = 4,
  parameter int USE_CYC = 3
)
(
  // secondary clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // bench wishes and grant pins seen on the wire
  input  wire logic [N-1:0] want_i,
  input  wire logic [N-1:0] gnt_n_i,
  input  wire logic [N-1:0] gnt_oe_i,
  // request pins and bus state
  output logic      [N-1:0] req_n_o,
  output logic      [N-1:0] served_o,
  output logic              bus_idle_o
);
  int busy_cnt;
  int owner;

  // a started master keeps the bus even if its grant is taken away
  // request per master
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_n_o  <= '1;
      served_o <= '0;
      busy_cnt <= 0;
      owner    <= 0;
    end
    else
    begin
      if (busy_cnt > 0)
        busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1)
        served_o[owner] <= 1'b1;
      for (int i = 0; i < N; i++)
      begin
        if (!want_i[i])
        begin
          served_o[i] <= 1'b0;
          req_n_o[i]  <= 1'b1;
        end
        else if (busy_cnt == 0 && gnt_oe_i[i] && !gnt_n_i[i] && !req_n_o[i])
        begin
          owner      <= i;
          busy_cnt   <= USE_CYC;
          req_n_o[i] <= 1'b1;
        end
        else if (!served_o[i] && !(busy_cnt > 0 && owner == i))
          req_n_o[i] <= 1'b0;
      end
    end
  end

  // bus busy while any master runs a transfer
  assign bus_idle_o = (busy_cnt == 0);
endmodule

`default_nettype wire

// ==== sbarc_top_tb.sv ====
// self-checking testbench of the secondary arbiter, reset and clock block
`timescale 1ns/100ps
`default_nettype none

module sbarc_top_tb;
  logic                  core_clk_i = 1'b0;
  logic                  sec_clk_i  = 1'b0;
  logic                  reset_i    = 1'b1;
  logic                  rst_ctl    = 1'b0;
  logic [4:0]            clk_dis    = 5'h00;
  sbarc_pkg::sbarc_pwr_t pwr        = sbarc_pkg::PWR_D0;
  logic                  cfn        = 1'b0;
  logic                  gate       = 1'b0;
  logic                  tm_n       = 1'b1;
  logic                  sen        = 1'b0;
  logic                  serr_n     = 1'b1;
  logic                  own_req    = 1'b0;
  logic                  perr_det   = 1'b0;
  logic [3:0]            want       = 4'h0;
  logic                  scan_en_o, scan_oe, chain, shift, capt, srst_n, serr_o;
  logic                  bus_idle, own_gnt, ad_drv, ad_zero, perr_n, perr_oe;
  logic [4:0]            clks;
  logic [3:0]            req_n, gnt_n, gnt_oe, served;
  wire                   scan_pin;
  int                    bad_count   = 0;
  int                    comparisons = 0;
  int                    hi_cnt [4];
  int                    order [$];

  // the scan enable pin is shared, the block wins while it drives
  assign scan_pin = scan_oe ? scan_en_o : sen;

  // primary clock 4 ns, link clock 48 ns with an odd offset
  initial forever #2 core_clk_i = ~core_clk_i;
  initial
  begin
    #7;
    forever #24 sec_clk_i = ~sec_clk_i;
  end

  sbarc_top u_sbarc_top (.core_clk_i(core_clk_i), .reset_i(reset_i), .sec_clk_i(sec_clk_i),
    .sec_reset_ctrl_i(rst_ctl), .sec_clk_disable_i(clk_dis), .power_state_i(pwr),
    .central_function_strap_i(cfn), .power_clock_gating_strap_i(gate),
    .scan_test_mode_n_i(tm_n), .scan_en_i(scan_pin), .scan_en_o(scan_en_o),
    .scan_en_oe_o(scan_oe), .scan_chain_en_o(chain), .scan_shift_o(shift),
    .scan_capture_o(capt), .sec_reset_n_o(srst_n), .sec_clock_outputs_o(clks),
    .sec_system_error_n_i(serr_n), .sec_system_error_o(serr_o), .sec_req_n_i(req_n),
    .sec_gnt_n_o(gnt_n), .sec_gnt_oe_o(gnt_oe), .own_bus_req_i(own_req),
    .bus_idle_i(bus_idle), .own_bus_grant_o(own_gnt), .ad_drive_o(ad_drv),
    .ad_zero_o(ad_zero), .parity_err_det_i(perr_det), .sec_parity_error_n_o(perr_n),
    .sec_parity_error_oe_o(perr_oe));

  sbarc_master_model u_sbarc_master_model (.clk_i(sec_clk_i), .rst_i(reset_i),
    .want_i(want), .gnt_n_i(gnt_n), .gnt_oe_i(gnt_oe), .req_n_o(req_n),
    .served_o(served), .bus_idle_o(bus_idle));

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timeout(input bit ok);
    if (!ok)
    begin
      chk(1'b0, "wait expired");
      summarize();
    end
  endtask

  // running outputs toggle every primary edge together, stopped ones sit low
  task automatic clk_chk(input logic [4:0] run);
    logic [4:0] prev;
    repeat (8) @(posedge core_clk_i);
    #1 prev = clks;
    repeat (3)
    begin
      @(posedge core_clk_i) #1;
      chk((prev & run) === 5'h00 || (prev & run) === run, "clock phase");
      chk(clks === (~prev & run), "clock outputs");
      prev = clks;
    end
  endtask

  // grant spacing and single owner watched on every link edge out of reset with the strap low
  always @(posedge sec_clk_i)
  begin
    if (!reset_i && !cfn)
    begin
      chk($countones(gnt_oe & ~gnt_n) <= 1, "two grants");
      for (int i = 0; i < 4; i++)
      begin
        if (gnt_n[i] === 1'b1)
          hi_cnt[i]++;
        else
        begin
          if (hi_cnt[i] > 0)
          begin
            chk(hi_cnt[i] >= 2, "grant back too soon");
            order.push_back(i);
          end
          hi_cnt[i] = 0;
        end
      end
    end
  end

  initial
  begin
    int t;
    repeat (4) @(posedge sec_clk_i);
    chk(srst_n === 1'b0 && clks === 5'h00, "reset state");
    @(posedge core_clk_i) reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk(srst_n === 1'b1, "reset release");
    @(posedge core_clk_i) rst_ctl <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk(srst_n === 1'b0, "software reset");
    repeat (5) @(posedge sec_clk_i);
    #1 chk(ad_drv === 1'b1 && ad_zero === 1'b1 && gnt_oe === 4'h0, "reset drive");
    chk(perr_oe === 1'b0, "reset float");
    @(posedge core_clk_i) rst_ctl <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk(srst_n === 1'b1, "software release");
    repeat (6) @(posedge sec_clk_i);
    #1 chk(ad_drv === 1'b1 && ad_zero === 1'b0, "park");
    // one master, then an immediate second request
    @(posedge sec_clk_i) want <= 4'h2;
    for (t = 0; t < 20 && gnt_n[1] !== 1'b0; t++) @(posedge sec_clk_i) #1;
    timeout(gnt_n[1] === 1'b0);
    chk(gnt_oe[1] === 1'b1 && ad_drv === 1'b0, "grant drive");
    for (t = 0; t < 20 && served !== 4'h2; t++) @(posedge sec_clk_i) #1;
    timeout(served === 4'h2);
    @(posedge sec_clk_i) want <= 4'h0;
    @(posedge sec_clk_i) want <= 4'h2;
    @(posedge sec_clk_i) #1;
    for (t = 0; t < 40 && served !== 4'h2; t++) @(posedge sec_clk_i) #1;
    timeout(served === 4'h2);
    @(posedge sec_clk_i) want <= 4'h0;
    repeat (4) @(posedge sec_clk_i);
    order.delete();
    @(posedge sec_clk_i) want <= 4'hF;
    for (t = 0; t < 200 && served !== 4'hF; t++) @(posedge sec_clk_i) #1;
    timeout(served === 4'hF);
    chk(order.size() == 4, "grant count");
    for (int k = 1; k < order.size(); k++)
      chk(order[k] == (order[k-1] + 1) % 4, "rotation");
    @(posedge sec_clk_i) want <= 4'h0;
    // power state and gating strap combinations
    for (int p = 0; p < 8; p++)
    begin
      @(posedge core_clk_i)
      begin
        pwr  <= sbarc_pkg::sbarc_pwr_t'(p[1:0]);
        gate <= p[2];
      end
      clk_chk((p[2] && p[1]) ? 5'h00 : 5'h1F);
    end
    @(posedge core_clk_i)
    begin
      pwr     <= sbarc_pkg::PWR_D0;
      clk_dis <= 5'h05;
    end
    clk_chk(5'h1A);
    @(posedge core_clk_i) clk_dis <= 5'h00;
    for (int v = 0; v < 2; v++)
    begin
      @(posedge core_clk_i) serr_n <= v[0];
      repeat (4) @(posedge core_clk_i);
      #1 chk(serr_o === ~v[0], "system error");
    end
    for (int s = 0; s < 4; s++)
    begin
      @(posedge core_clk_i)
      begin
        tm_n <= s[1];
        sen  <= s[0];
      end
      repeat (5) @(posedge core_clk_i);
      #1 chk(chain === ~s[1] && shift === (~s[1] & ~s[0]), "scan shift");
      chk(capt === (~s[1] & s[0]), "scan capture");
      if (s[1])
        chk(scan_oe === 1'b1 && scan_en_o === 1'b0, "scan pin drive");
    end
    @(posedge sec_clk_i) perr_det <= 1'b1;
    @(posedge sec_clk_i) perr_det <= 1'b0;
    #1 chk(perr_n === 1'b0 && perr_oe === 1'b1, "parity low");
    @(posedge sec_clk_i) #1 chk(perr_n === 1'b1 && perr_oe === 1'b1, "parity high");
    @(posedge sec_clk_i) #1 chk(perr_oe === 1'b0, "parity float");
    // a new error during the high cycle pulls the pin low again
    @(posedge sec_clk_i) perr_det <= 1'b1;
    @(posedge sec_clk_i) perr_det <= 1'b0;
    @(posedge sec_clk_i) perr_det <= 1'b1;
    @(posedge sec_clk_i) perr_det <= 1'b0;
    #1 chk(perr_n === 1'b0 && perr_oe === 1'b1, "parity restart");
    repeat (3) @(posedge sec_clk_i);
    #1 chk(perr_oe === 1'b0, "parity restart float");
    // external arbiter: grant zero carries our request, request zero our grant
    @(posedge core_clk_i) cfn <= 1'b1;
    @(posedge sec_clk_i) own_req <= 1'b1;
    repeat (6) @(posedge sec_clk_i);
    #1 chk(gnt_n[0] === 1'b0 && gnt_oe === 4'h1 && own_gnt === 1'b0, "own request");
    @(posedge sec_clk_i)
    begin
      own_req <= 1'b0;
      want    <= 4'h1;
    end
    repeat (6) @(posedge sec_clk_i);
    #1 chk(gnt_n[0] === 1'b1 && own_gnt === 1'b1, "own grant");
    summarize();
  end
endmodule

`default_nettype wire
